// [core/wbh_pkg.sv]
// Package: constants, types and helpers for the word bus host port
package wbh_pkg;

  // ****************************************************************
  // Widths and timing
  // ****************************************************************
  localparam int unsigned CLK_PERIOD_NS = 20;
  localparam int unsigned RD_GAP_NS = 30;
  localparam int unsigned WR_GAP_NS = 55;
  localparam int unsigned WR_RD_GAP_NS = 80;
  // Least times round up to whole clock cycles
  localparam logic [2:0] RD_GAP_CYC =
    3'((RD_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [2:0] WR_GAP_CYC =
    3'((WR_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [2:0] WR_RD_GAP_CYC =
    3'((WR_RD_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [2:0] RD_WR_GAP_CYC = 3'h1;
  localparam int unsigned INIT_CYCLES = 1025;

  // ****************************************************************
  // Reset values and encodings
  // ****************************************************************
  localparam logic [2:0] STRETCH_RESET = 3'h5;
  localparam logic [2:0] MODE_EXPANDED = 3'h5;
  localparam logic [2:0] MODE_RESET = 3'h0;
  localparam logic [15:0] MARKER_BUSY = 16'h0000;
  localparam logic [15:0] MARKER_DONE = 16'h0815;
  localparam logic [15:0] MARKER_OFFSET = 16'h0000;

  // ****************************************************************
  // Region boundaries of the global address space
  // ****************************************************************
  localparam logic [22:0] REG3_LO = 23'h000800;
  localparam logic [22:0] REG2_LO = 23'h100000;
  localparam logic [22:0] REG1_LO = 23'h200000;
  localparam logic [22:0] REG0_LO = 23'h400000;

  typedef struct packed {
    logic write;
    logic [6:0] page;
    logic [15:0] local_addr;
    logic [15:0] wdata;
  } wbh_req_t;

  typedef struct packed {
    logic [2:0] mode_bits;
    logic [2:0] stretch_count_field;
    logic external_wait_enable;
  } wbh_cfg_t;

  // Active-low region select for one global address
  function automatic logic [3:0] region_sel_n(input logic [22:0] ga);
    logic [3:0] s;
    s = 4'hf;
    if (ga >= REG0_LO) begin
      s = 4'he;
    end else if (ga >= REG1_LO) begin
      s = 4'hd;
    end else if (ga >= REG2_LO) begin
      s = 4'hb;
    end else if (ga >= REG3_LO) begin
      s = 4'h7;
    end
    return s;
  endfunction

endpackage

// [core/wbh_init_marker.sv]
// Init marker: tracks the partner's start-up count after hard reset
`timescale 1ns/100ps

module wbh_init_marker #(
  parameter int unsigned INIT_CYC = wbh_pkg::INIT_CYCLES
) (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic hard_rst,
  output logic [15:0] init_done_marker,
  output logic init_done
);

  logic [10:0] cnt_q;
  logic [15:0] marker_q;

  // ****************************************************************
  // Start-up counter, restarts while hard reset is held
  // ****************************************************************
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      cnt_q <= 11'h000;
    end else if (hard_rst) begin
      cnt_q <= 11'h000;
    end else if (cnt_q != 11'(INIT_CYC)) begin
      cnt_q <= cnt_q + 11'h001;
    end
  end

  // Marker reads busy until the count completes
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      marker_q <= wbh_pkg::MARKER_BUSY;
    end else if (!hard_rst && cnt_q == 11'(INIT_CYC - 1)) begin
      marker_q <= wbh_pkg::MARKER_DONE;
    end else if (hard_rst) begin
      marker_q <= wbh_pkg::MARKER_BUSY;
    end
  end

  assign init_done_marker = marker_q;
  assign init_done = (marker_q == wbh_pkg::MARKER_DONE);

  property p_marker_busy;
    @(posedge core_clk) disable iff (sys_rst)
      (cnt_q < 11'(INIT_CYC)) |-> (marker_q == wbh_pkg::MARKER_BUSY);
  endproperty
  a_marker_busy: assert property (p_marker_busy)
    else $error("Marker not zero during start-up");

  property p_marker_done;
    @(posedge core_clk) disable iff (sys_rst)
      (!hard_rst && cnt_q == 11'(INIT_CYC - 1)) |=>
        (marker_q == wbh_pkg::MARKER_DONE);
  endproperty
  a_marker_done: assert property (p_marker_done)
    else $error("Marker not set at end of start-up count");

endmodule // wbh_init_marker

// [core/wbh_host_port.sv]
// Host external bus port: word access engine to an async word slave
`timescale 1ns/100ps

module wbh_host_port (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic hard_rst,
  input wire logic cfg_wr,
  input wire wbh_pkg::wbh_cfg_t cfg_in,
  input wire logic req_valid,
  input wire wbh_pkg::wbh_req_t req_in,
  output logic req_ready,
  output logic rsp_valid,
  output logic [15:0] rsp_data,
  output logic [15:0] init_done_marker,
  output logic [22:0] bus_addr,
  output logic [15:0] bus_dat_o,
  output logic bus_dat_oe,
  input wire logic [15:0] bus_dat_i,
  output logic bus_we_n,
  output logic bus_oe_n,
  output logic [3:0] region_select_n
);

  typedef enum logic [1:0] {WBH_IDLE, WBH_ACCESS, WBH_GAP} wbh_state_t;

  wbh_state_t state_q;
  wbh_pkg::wbh_cfg_t cfg_q;
  logic [3:0] cnt_q;
  logic [2:0] gap_q;
  logic last_wr_q;
  logic cur_wr_q;
  logic ready_q;
  logic rsp_valid_q;
  logic [15:0] rsp_data_q;
  logic [15:0] marker_q;
  logic [22:0] addr_q;
  logic [15:0] dat_o_q;
  logic dat_oe_q;
  logic we_n_q;
  logic oe_n_q;
  logic [3:0] sel_n_q;
  logic [15:0] marker_w;
  logic take;
  logic [22:0] req_ga;
  logic [2:0] next_gap;

  // ****************************************************************
  // Partner start-up tracking
  // ****************************************************************
  wbh_init_marker #(
    .INIT_CYC(wbh_pkg::INIT_CYCLES)
  ) u_marker (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .hard_rst(hard_rst),
    .init_done_marker(marker_w),
    .init_done()
  );

  // Marker copy kept in a flop so the output is registered
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      marker_q <= wbh_pkg::MARKER_BUSY;
    end else begin
      marker_q <= marker_w;
    end
  end

  // ****************************************************************
  // Configuration: mode bits and stretch field
  // ****************************************************************
  // Software sets stretch before switching to expanded mode
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      cfg_q.mode_bits <= wbh_pkg::MODE_RESET;
      cfg_q.stretch_count_field <= wbh_pkg::STRETCH_RESET;
      cfg_q.external_wait_enable <= 1'b0;
    end else if (cfg_wr) begin
      cfg_q <= cfg_in;
    end
  end

  // ****************************************************************
  // Request acceptance and address forming
  // ****************************************************************
  // Global address is the page index over the local word address
  assign req_ga = {req_in.page, req_in.local_addr};
  assign take = req_valid && ready_q;
  // Idle time chosen from the direction of the finished access and the one before it
  always_comb begin
    next_gap = wbh_pkg::RD_WR_GAP_CYC;
    if (last_wr_q && cur_wr_q) begin
      next_gap = wbh_pkg::WR_GAP_CYC;
    end else if (!cur_wr_q && last_wr_q) begin
      next_gap = wbh_pkg::WR_RD_GAP_CYC;
    end else if (!cur_wr_q) begin
      next_gap = wbh_pkg::RD_GAP_CYC;
    end
  end

  // ****************************************************************
  // Access sequencer
  // ****************************************************************
  // Wait input is ignored: this port only uses fixed stretching
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_q <= WBH_IDLE;
      cnt_q <= 4'h0;
      gap_q <= 3'h0;
      cur_wr_q <= 1'b0;
      last_wr_q <= 1'b0;
    end else begin
      unique case (state_q)
        WBH_IDLE: begin
          if (take) begin
            state_q <= WBH_ACCESS;
            // Base cycle plus field+1 stretch cycles
            cnt_q <= {1'b0, cfg_q.stretch_count_field} + 4'h1;
            cur_wr_q <= req_in.write;
          end
        end
        WBH_ACCESS: begin
          if (cnt_q == 4'h0) begin
            state_q <= WBH_GAP;
            gap_q <= next_gap;
            last_wr_q <= cur_wr_q;
          end else begin
            cnt_q <= cnt_q - 4'h1;
          end
        end
        WBH_GAP: begin
          if (gap_q <= 3'h1) begin
            state_q <= WBH_IDLE;
          end
          gap_q <= gap_q - 3'h1;
        end
      endcase
    end
  end

  // Ready only in expanded mode, idle, and never on the take edge
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      ready_q <= 1'b0;
    end else begin
      ready_q <= (cfg_q.mode_bits == wbh_pkg::MODE_EXPANDED) &&
        (state_q == WBH_IDLE) && !take;
    end
  end

  // ****************************************************************
  // Pin drivers
  // ****************************************************************
  // Write enable drops one cycle ahead of the select
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      addr_q <= 23'h000000;
      dat_o_q <= 16'h0000;
      dat_oe_q <= 1'b0;
      we_n_q <= 1'b1;
      oe_n_q <= 1'b1;
      sel_n_q <= 4'hf;
    end else if (take) begin
      addr_q <= req_ga;
      dat_o_q <= req_in.wdata;
      dat_oe_q <= req_in.write;
      we_n_q <= !req_in.write;
      oe_n_q <= req_in.write;
      sel_n_q <= wbh_pkg::region_sel_n(req_ga);
    end else if (state_q == WBH_ACCESS && cnt_q == 4'h1) begin
      we_n_q <= 1'b1;
    end else if (state_q == WBH_ACCESS && cnt_q == 4'h0) begin
      we_n_q <= 1'b1;
      oe_n_q <= 1'b1;
      dat_oe_q <= 1'b0;
      sel_n_q <= 4'hf;
    end
  end

  // Read data captured on the closing edge, full word only
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      rsp_valid_q <= 1'b0;
      rsp_data_q <= 16'h0000;
    end else begin
      rsp_valid_q <= (state_q == WBH_ACCESS) && (cnt_q == 4'h0);
      if (state_q == WBH_ACCESS && cnt_q == 4'h0 && !cur_wr_q) begin
        rsp_data_q <= bus_dat_i;
      end
    end
  end

  assign req_ready = ready_q;
  assign rsp_valid = rsp_valid_q;
  assign rsp_data = rsp_data_q;
  assign init_done_marker = marker_q;
  assign bus_addr = addr_q;
  assign bus_dat_o = dat_o_q;
  assign bus_dat_oe = dat_oe_q;
  assign bus_we_n = we_n_q;
  assign bus_oe_n = oe_n_q;
  assign region_select_n = sel_n_q;

  // ****************************************************************
  // Checks
  // ****************************************************************
  logic [4:0] oe_run_q;
  logic [4:0] we_run_q;
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      oe_run_q <= 5'h00;
      we_run_q <= 5'h00;
    end else begin
      oe_run_q <= oe_n_q ? 5'h00 : oe_run_q + 5'h01;
      we_run_q <= we_n_q ? 5'h00 : we_run_q + 5'h01;
    end
  end

  property p_rd_len;
    @(posedge core_clk) disable iff (sys_rst)
      $rose(oe_n_q) |->
        (oe_run_q == {2'b00, cfg_q.stretch_count_field} + 5'h02);
  endproperty
  a_rd_len: assert property (p_rd_len)
    else $error("Read strobe length differs from stretch setting");

  property p_wr_len;
    @(posedge core_clk) disable iff (sys_rst)
      $rose(we_n_q) |->
        (we_run_q == {2'b00, cfg_q.stretch_count_field} + 5'h01);
  endproperty
  a_wr_len: assert property (p_wr_len)
    else $error("Write strobe length differs from stretch setting");

  // Until software configures the port the field keeps six stretch cycles
  property p_stretch_reset;
    @(posedge core_clk) disable iff (sys_rst)
      cfg_q.mode_bits == wbh_pkg::MODE_RESET |->
        cfg_q.stretch_count_field == wbh_pkg::STRETCH_RESET;
  endproperty
  a_stretch_reset: assert property (p_stretch_reset)
    else $error("Stretch field lost its reset value");

  sequence s_we_up;
    $rose(we_n_q) && sel_n_q != 4'hf;
  endsequence
  property p_we_before_sel;
    @(posedge core_clk) disable iff (sys_rst)
      s_we_up and !cur_wr_q == 1'b0 |=> sel_n_q == 4'hf;
  endproperty
  a_we_before_sel: assert property (p_we_before_sel)
    else $error("Select not released one cycle after write enable");

  property p_rd_gap;
    @(posedge core_clk) disable iff (sys_rst)
      $rose(oe_n_q) |-> oe_n_q [*3];
  endproperty
  a_rd_gap: assert property (p_rd_gap)
    else $error("Read strobe high time too short");

  property p_wr_gap;
    @(posedge core_clk) disable iff (sys_rst)
      $rose(we_n_q) |-> we_n_q [*4];
  endproperty
  a_wr_gap: assert property (p_wr_gap)
    else $error("Write strobe high time too short");

  // Four whole cycles of 20 ns cover the 80 ns write to read spacing
  property p_wr_rd_gap;
    @(posedge core_clk) disable iff (sys_rst)
      $rose(we_n_q) |-> oe_n_q [*4];
  endproperty
  a_wr_rd_gap: assert property (p_wr_rd_gap)
    else $error("Write to read spacing too short");

  property p_region;
    @(posedge core_clk) disable iff (sys_rst)
      take |=> sel_n_q == wbh_pkg::region_sel_n($past(req_ga)) &&
        bus_addr == $past(req_ga);
  endproperty
  a_region: assert property (p_region)
    else $error("Region select or address mismatch");

  property p_mode;
    @(posedge core_clk) disable iff (sys_rst)
      take |-> cfg_q.mode_bits == wbh_pkg::MODE_EXPANDED;
  endproperty
  a_mode: assert property (p_mode)
    else $error("Access taken outside expanded mode");

  property p_page;
    @(posedge core_clk) disable iff (sys_rst)
      take |=> bus_addr[22:16] == $past(req_in.page);
  endproperty
  a_page: assert property (p_page)
    else $error("Page index not on upper address bits");

endmodule // wbh_host_port

// [tb/wbh_word_slave.sv]
// Partner model: async word slave on the far side of the host port
`timescale 1ns/100ps

module wbh_word_slave #(
  parameter int DLY = 3
) (
  input wire logic core_clk,
  input wire logic [22:0] bus_addr,
  input wire logic [15:0] bus_dat_o,
  input wire logic bus_dat_oe,
  input wire logic bus_we_n,
  input wire logic bus_oe_n,
  output logic [15:0] bus_dat_i
);
  // ****************************************************************
  // Storage and read path
  // ****************************************************************
  logic [15:0] mem_q [16];
  logic [15:0] last_q = 16'h0000;
  int oe_cnt_q = 0;

  initial begin
    for (int i = 0; i < 16; i++) begin
      mem_q[i] = 16'h0000;
    end
  end

  // Enable pin is tied low, so no select is looked at
  // Straps fixed for async memory mode; whole words only
  always @(posedge core_clk) begin
    if (!bus_we_n && bus_dat_oe) begin
      mem_q[bus_addr[4:1]] <= bus_dat_o;
    end
    oe_cnt_q <= bus_oe_n ? 0 : oe_cnt_q + 1;
    last_q <= bus_dat_i;
  end

  // Slow answer: data valid only after DLY cycles, else a toggling pattern
  always_comb begin
    if (!bus_oe_n && oe_cnt_q >= DLY) begin
      bus_dat_i = mem_q[bus_addr[4:1]];
    end else begin
      bus_dat_i = ~last_q;
    end
  end
endmodule // wbh_word_slave

// [tb/tb_async_word_bus_host_access.sv]
// Testbench: host port accesses, gaps, selects and start-up marker
`timescale 1ns/100ps

`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin \
  mismatches++; $display("Error at %0t: value mismatch", $time); end end

module tb_async_word_bus_host_access;
  // ****************************************************************
  // Signals, design and partner
  // ****************************************************************
  logic core_clk = 1'b0, sys_rst = 1'b1, hard_rst = 1'b0, cfg_wr = 1'b0;
  wbh_pkg::wbh_cfg_t cfg_in = '0;
  wbh_pkg::wbh_req_t req_in = '0;
  logic req_valid = 1'b0;
  logic req_ready, rsp_valid, bus_dat_oe, bus_we_n, bus_oe_n;
  logic [15:0] rsp_data, init_done_marker, bus_dat_o, bus_dat_i;
  logic [22:0] bus_addr;
  logic [3:0] region_select_n;
  logic [15:0] shadow [16];
  logic last_wr = 1'b0;
  int mismatches = 0, tests_run = 0, cyc = 0, last_low = -100;
  int seed = 32'h3377;
  logic [22:0] corner [9] = '{23'h000800, 23'h0fffff, 23'h100000,
    23'h1fffff, 23'h200000, 23'h3fffff, 23'h400000, 23'h7fffff,
    23'h0007fe};

  wbh_host_port uut (.core_clk, .sys_rst, .hard_rst, .cfg_wr, .cfg_in,
    .req_valid, .req_in, .req_ready, .rsp_valid, .rsp_data,
    .init_done_marker, .bus_addr, .bus_dat_o, .bus_dat_oe, .bus_dat_i,
    .bus_we_n, .bus_oe_n, .region_select_n);
  // Answer after one strobe cycle so the shortest stretch setting reads
  wbh_word_slave #(.DLY(1)) partner (.core_clk, .bus_addr, .bus_dat_o,
    .bus_dat_oe,
    .bus_we_n, .bus_oe_n, .bus_dat_i);

  initial begin
    forever #10 core_clk = ~core_clk;
  end

  // Cycle ceiling well above the expected run, cuts a hang short
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      mismatches++;
      summarize();
    end
  end

  // Expected active-low select, worked from the region boundaries
  function automatic logic [3:0] exp_sel(input logic [22:0] ga);
    if (ga[22]) return 4'he;
    if (ga[21]) return 4'hd;
    if (ga[20]) return 4'hb;
    return (ga >= 23'h000800) ? 4'h7 : 4'hf;
  endfunction

  task automatic summarize();
    $display("Counts: %0d checks, %0d mismatches", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic cfg(input logic [2:0] mode, input logic [2:0] fld);
    @(negedge core_clk);
    cfg_in = {mode, fld, 1'b0};
    cfg_wr = 1'b1;
    @(negedge core_clk);
    cfg_wr = 1'b0;
    repeat (2) @(negedge core_clk);
  endtask

  // One whole-word access; measures strobe width, gap and select timing
  task automatic access(input logic wr, input logic [22:0] ga,
                        input logic [15:0] wd, input logic [2:0] fld);
    int low, first, lastl, n, need;
    logic sep;
    logic strobe;
    low = 0;
    first = -1;
    lastl = 0;
    n = 0;
    sep = 1'b0;
    @(negedge core_clk);
    req_valid = 1'b1;
    req_in = {wr, ga, wd};
    while (req_ready !== 1'b1 && n < 50) begin
      @(negedge core_clk);
      n++;
    end
    @(posedge core_clk);
    for (int i = 0; i < 40; i++) begin
      @(negedge core_clk);
      req_valid = 1'b0;
      strobe = wr ? bus_we_n : bus_oe_n;
      if (strobe === 1'b0) begin
        if (first < 0) begin
          first = cyc;
          `CHK(region_select_n, exp_sel(ga))
          `CHK(bus_addr, ga)
          if (wr) `CHK({bus_dat_oe, bus_dat_o}, {1'b1, wd})
        end
        low++;
        lastl = cyc;
      end else if (wr && low > 0 && rsp_valid !== 1'b1 &&
                   region_select_n === exp_sel(ga)) begin
        sep = 1'b1;
      end
      if (rsp_valid === 1'b1) break;
    end
    `CHK(rsp_valid, 1'b1)
    `CHK(low, wr ? fld + 1 : fld + 2)
    need = last_wr ? (wr ? wbh_pkg::WR_GAP_CYC : wbh_pkg::WR_RD_GAP_CYC)
                   : (wr ? wbh_pkg::RD_WR_GAP_CYC : wbh_pkg::RD_GAP_CYC);
    `CHK(first - last_low - 1 >= need, 1'b1)
    last_low = lastl;
    last_wr = wr;
    if (wr) begin
      shadow[ga[4:1]] = wd;
      `CHK(bus_dat_oe, 1'b0)
      if (exp_sel(ga) != 4'hf) `CHK(sep, 1'b1)
    end else begin
      `CHK(rsp_data, shadow[ga[4:1]])
    end
  endtask

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    for (int i = 0; i < 16; i++) begin
      shadow[i] = 16'h0000;
    end
    repeat (6) @(posedge core_clk);
    @(negedge core_clk);
    sys_rst = 1'b0;
    @(negedge core_clk);
    `CHK(req_ready, 1'b0)
    `CHK({bus_oe_n, bus_we_n, region_select_n}, 6'h3f)
    `CHK(init_done_marker, 16'h0000)
    $display("Test reset done");
    // Requests in a wrong mode are never taken
    req_valid = 1'b1;
    cfg(3'h7, 3'h5);
    repeat (8) @(negedge core_clk);
    `CHK({req_ready, bus_oe_n, bus_we_n}, 3'h3)
    req_valid = 1'b0;
    $display("Test refused mode done");
    // Start-up marker polled after a partner hard reset
    hard_rst = 1'b1;
    repeat (5) @(negedge core_clk);
    `CHK(init_done_marker, 16'h0000)
    hard_rst = 1'b0;
    repeat (1025) @(negedge core_clk);
    `CHK(init_done_marker, 16'h0000)
    @(negedge core_clk);
    `CHK(init_done_marker, 16'h0815)
    $display("Test marker done");
    // Accesses start after the marker shows completion; ready does not wait for it
    cfg(3'h5, 3'h5);
    `CHK(req_ready, 1'b1)
    for (int i = 0; i < 9; i++) begin
      access(1'(9'h12c >> i), corner[i], 16'($random(seed)), 3'h5);
    end
    $display("Test boundaries back to back done");
    for (int f = 0; f < 8; f++) begin
      cfg(3'h5, 3'(f));
      repeat (8) begin
        access(1'($random(seed)), 23'($random(seed)),
               16'($random(seed)), 3'(f));
      end
    end
    $display("Test random stretch sweep done");
    summarize();
  end
endmodule // tb_async_word_bus_host_access
